//--- hdl/ipc_channel_bank.sv
// Purpose: lockable data channels and event structures shared by two cores
// Assumes: each core issues at most one request per cycle
// Notes: same-cycle requests are served main core first, then secondary core

`timescale 1ns/10ps

module ipc_channel_bank
  import irq_ipc_pkg::*;
#(
  parameter int CHANS = CHAN_N,
  parameter int DW = DATA_W
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [CPU_N-1:0] reqValid,
  input wire logic [CPU_N-1:0][2:0] reqOp,
  input wire logic [CPU_N-1:0][CHAN_IDX_W-1:0] reqChan,
  input wire logic [CPU_N-1:0][DW-1:0] reqData,
  output logic [CPU_N-1:0] ackValid,
  output logic [CPU_N-1:0] ackOk,
  output logic [CPU_N-1:0][DW-1:0] ackData,
  output logic [CPU_N-1:0][CHANS-1:0] evtIrq,
  output logic [CHANS-1:0] lockState
);

  // ****************************************
  // channel and event state
  // ****************************************
  logic [CHANS-1:0] lock_q, lock_d;
  logic [CHANS-1:0] owner_q, owner_d;
  logic [CHANS-1:0][DW-1:0] data_q, data_d;
  logic [CPU_N-1:0][CHANS-1:0] pend_q, pend_d;
  logic [CPU_N-1:0] ackValid_q, ackValid_d, ackOk_q, ackOk_d;
  logic [CPU_N-1:0][DW-1:0] ackData_q, ackData_d;

  always_comb begin
    logic [CHAN_IDX_W-1:0] ch;
    logic [CPU_N-1:0][CHANS-1:0] setM, clrM;
    ch = '0;
    setM = '0;
    clrM = '0;
    lock_d = lock_q;
    owner_d = owner_q;
    data_d = data_q;
    ackValid_d = '0;
    ackOk_d = '0;
    ackData_d = ackData_q;
    // main core first: its acquire is seen by the secondary one in the same cycle
    for (int c = 0; c < CPU_N; c++) begin
      if (reqValid[c]) begin
        ch = reqChan[c];
        ackValid_d[c] = 1'b1;
        ackData_d[c] = data_d[ch];
        case (ipc_op_t'(reqOp[c]))
          OP_READ: begin
            ackOk_d[c] = 1'b1;
          end
          OP_WRITE: begin
            if (lock_d[ch] && owner_d[ch] == c[0]) begin
              data_d[ch] = reqData[c];
              ackOk_d[c] = 1'b1;
            end
          end
          OP_ACQUIRE: begin
            if (!lock_d[ch]) begin
              lock_d[ch] = 1'b1;
              owner_d[ch] = c[0];
              ackOk_d[c] = 1'b1;
            end
          end
          OP_RELEASE: begin
            if (lock_d[ch] && owner_d[ch] == c[0]) begin
              lock_d[ch] = 1'b0;
              setM[c == MAIN_CPU ? SEC_CPU : MAIN_CPU][ch] = 1'b1;
              ackOk_d[c] = 1'b1;
            end
          end
          OP_NOTIFY: begin
            setM[c == MAIN_CPU ? SEC_CPU : MAIN_CPU][ch] = 1'b1;
            ackOk_d[c] = 1'b1;
          end
          OP_CLEAR: begin
            clrM[c][ch] = 1'b1;
            ackOk_d[c] = 1'b1;
          end
          default: begin
            ackOk_d[c] = 1'b0;
          end
        endcase
      end
    end
    // a new event beats a clear of the same bit
    pend_d = (pend_q & ~clrM) | setM;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      lock_q <= '0;
      owner_q <= '0;
      data_q <= {CHANS{DW'(DATA_RST)}};
      pend_q <= '0;
      ackValid_q <= '0;
      ackOk_q <= '0;
      ackData_q <= {CPU_N{DW'(DATA_RST)}};
    end else begin
      lock_q <= lock_d;
      owner_q <= owner_d;
      data_q <= data_d;
      pend_q <= pend_d;
      ackValid_q <= ackValid_d;
      ackOk_q <= ackOk_d;
      ackData_q <= ackData_d;
    end
  end

  assign ackValid = ackValid_q;
  assign ackOk = ackOk_q;
  assign ackData = ackData_q;
  assign evtIrq = pend_q;
  assign lockState = lock_q;

  // ****************************************
  // checks
  // ****************************************
  logic bothAcq;
  assign bothAcq = (reqValid == 2'h3) && (ipc_op_t'(reqOp[0]) == OP_ACQUIRE)
    && (ipc_op_t'(reqOp[1]) == OP_ACQUIRE) && (reqChan[0] == reqChan[1]);

  a_lock_exclusive: assert property (@(posedge clk) disable iff (!nrst)
    bothAcq |=> !(ackOk[0] && ackOk[1]))
    else $error("both cores obtained one lock");

  a_acquire_locks: assert property (@(posedge clk) disable iff (!nrst)
    (reqValid[1] && ipc_op_t'(reqOp[1]) == OP_ACQUIRE) |=> lockState[$past(reqChan[1])])
    else $error("channel not locked after acquire");

  a_notify_raises: assert property (@(posedge clk) disable iff (!nrst)
    (reqValid[0] && ipc_op_t'(reqOp[0]) == OP_NOTIFY) |=> evtIrq[1][$past(reqChan[0])])
    else $error("notify did not reach secondary core");

  a_write_visible: assert property (@(posedge clk) disable iff (!nrst)
    (reqValid == 2'h1 && ipc_op_t'(reqOp[0]) == OP_WRITE) ##1
    (ackOk[0] && reqValid == 2'h2 && ipc_op_t'(reqOp[1]) == OP_READ
    && reqChan[1] == $past(reqChan[0]))
    |=> ackData[1] == $past(reqData[0], 2))
    else $error("written data not read back");

  c_acquire_race: cover property (@(posedge clk) disable iff (!nrst) bothAcq);
  c_release_event: cover property (@(posedge clk) disable iff (!nrst)
    reqValid[1] && ipc_op_t'(reqOp[1]) == OP_RELEASE ##1 ackOk[1]);

endmodule

//--- hdl/irq_route_ipc.sv
// Purpose: interrupt delivery to a main and a secondary core, plus core-to-core channels
// Assumes: sources, configuration and core requests are synchronous to clk
// Notes: every output is registered, so lines follow their sources by one cycle

`timescale 1ns/10ps

module irq_route_ipc
  import irq_ipc_pkg::*;
#(
  parameter int NSRC = SRC_N,
  parameter int NWAKE = WAKE_N
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [NSRC-1:0] srcIrq,
  input wire logic [NSRC-1:0][MAIN_PRIO_W-1:0] mainPrio,
  input wire logic [SEC_HW_N-1:0][NSRC-1:0] secMap,
  input wire logic [SEC_N-1:0][SEC_PRIO_W-1:0] secPrio,
  input wire logic [SEC_SW_N-1:0] secSwSet,
  input wire logic [SEC_SW_N-1:0] secSwClr,
  input wire logic [CPU_N-1:0][NMI_PER_CPU-1:0] nmiEn,
  input wire logic [CPU_N-1:0][NMI_PER_CPU-1:0][SRC_IDX_W-1:0] nmiSel,
  input wire logic [NWAKE-1:0] wakeMask,
  input wire logic deepSleep,
  input wire logic [CPU_N-1:0] ipcReqValid,
  input wire logic [CPU_N-1:0][2:0] ipcReqOp,
  input wire logic [CPU_N-1:0][CHAN_IDX_W-1:0] ipcReqChan,
  input wire logic [CPU_N-1:0][DATA_W-1:0] ipcReqData,
  output logic [NSRC-1:0] mainCpuIrq,
  output logic mainBestValid,
  output logic [SRC_IDX_W-1:0] mainBestSrc,
  output logic [MAIN_PRIO_W-1:0] mainBestPrio,
  output logic [SEC_N-1:0] secCpuIrq,
  output logic secBestValid,
  output logic [SEC_IDX_W-1:0] secBestIdx,
  output logic [CPU_N-1:0] nmiOut,
  output logic wakeReq,
  output logic [CPU_N-1:0] ipcAckValid,
  output logic [CPU_N-1:0] ipcAckOk,
  output logic [CPU_N-1:0][DATA_W-1:0] ipcAckData,
  output logic [CPU_N-1:0][CHAN_N-1:0] ipcEvtIrq,
  output logic [CHAN_N-1:0] ipcLockState
);

  // ****************************************
  // routing state
  // ****************************************
  logic [NSRC-1:0] mainIrq_q, mainIrq_d;
  logic mainValid_q, mainValid_d;
  logic [SRC_IDX_W-1:0] mainSrc_q, mainSrc_d;
  logic [MAIN_PRIO_W-1:0] mainPrio_q, mainPrio_d;
  logic [SEC_HW_N-1:0] secHw_q, secHw_d;
  logic [SEC_SW_N-1:0] secSw_q, secSw_d;
  logic secValid_q, secValid_d;
  logic [SEC_IDX_W-1:0] secIdx_q, secIdx_d;
  logic [CPU_N-1:0] nmi_q, nmi_d;
  logic wake_q, wake_d;

  always_comb begin
    logic [SEC_N-1:0] secAll;
    logic [SEC_PRIO_W-1:0] secBestPrio;
    secAll = '0;
    secBestPrio = '0;
    mainIrq_d = srcIrq;
    // lowest priority value wins, ties go to the lower number
    mainValid_d = 1'b0;
    mainSrc_d = '0;
    mainPrio_d = '0;
    for (int i = 0; i < NSRC; i++) begin
      if (srcIrq[i] && (!mainValid_d || mainPrio[i] < mainPrio_d)) begin
        mainValid_d = 1'b1;
        mainSrc_d = SRC_IDX_W'(i);
        mainPrio_d = mainPrio[i];
      end
    end
    for (int l = 0; l < SEC_HW_N; l++) begin
      secHw_d[l] = |(srcIrq & secMap[l]);
    end
    // software set wins over a clear in the same cycle
    secSw_d = (secSw_q & ~secSwClr) | secSwSet;
    secAll = {secSw_d, secHw_d};
    secValid_d = 1'b0;
    secIdx_d = '0;
    for (int j = 0; j < SEC_N; j++) begin
      if (secAll[j] && (!secValid_d || secPrio[j] < secBestPrio)) begin
        secValid_d = 1'b1;
        secIdx_d = SEC_IDX_W'(j);
        secBestPrio = secPrio[j];
      end
    end
    nmi_d = '0;
    for (int c = 0; c < CPU_N; c++) begin
      for (int k = 0; k < NMI_PER_CPU; k++) begin
        if (nmiEn[c][k] && int'(nmiSel[c][k]) < NSRC) begin
          nmi_d[c] = nmi_d[c] | srcIrq[nmiSel[c][k]];
        end
      end
    end
    wake_d = deepSleep && |(srcIrq[NWAKE-1:0] & wakeMask);
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      mainIrq_q <= '0;
      mainValid_q <= 1'b0;
      mainSrc_q <= '0;
      mainPrio_q <= '0;
      secHw_q <= '0;
      secSw_q <= '0;
      secValid_q <= 1'b0;
      secIdx_q <= '0;
      nmi_q <= '0;
      wake_q <= 1'b0;
    end else begin
      mainIrq_q <= mainIrq_d;
      mainValid_q <= mainValid_d;
      mainSrc_q <= mainSrc_d;
      mainPrio_q <= mainPrio_d;
      secHw_q <= secHw_d;
      secSw_q <= secSw_d;
      secValid_q <= secValid_d;
      secIdx_q <= secIdx_d;
      nmi_q <= nmi_d;
      wake_q <= wake_d;
    end
  end

  assign mainCpuIrq = mainIrq_q;
  assign mainBestValid = mainValid_q;
  assign mainBestSrc = mainSrc_q;
  assign mainBestPrio = mainPrio_q;
  assign secCpuIrq = {secSw_q, secHw_q};
  assign secBestValid = secValid_q;
  assign secBestIdx = secIdx_q;
  assign nmiOut = nmi_q;
  assign wakeReq = wake_q;

  // ****************************************
  // core-to-core channels
  // ****************************************
  ipc_channel_bank #(
    .CHANS(CHAN_N),
    .DW(DATA_W)
  ) u_ipc (
    .clk(clk),
    .nrst(nrst),
    .reqValid(ipcReqValid),
    .reqOp(ipcReqOp),
    .reqChan(ipcReqChan),
    .reqData(ipcReqData),
    .ackValid(ipcAckValid),
    .ackOk(ipcAckOk),
    .ackData(ipcAckData),
    .evtIrq(ipcEvtIrq),
    .lockState(ipcLockState)
  );

  // ****************************************
  // checks
  // ****************************************
  a_main_direct: assert property (@(posedge clk) disable iff (!nrst)
    nrst |=> mainCpuIrq == $past(srcIrq))
    else $error("main core line does not follow its source");

  a_sec_or_map: assert property (@(posedge clk) disable iff (!nrst)
    (|(srcIrq & secMap[0])) |=> secCpuIrq[0])
    else $error("mapped source did not raise secondary line 0");

  a_sw_sticky: assert property (@(posedge clk) disable iff (!nrst)
    (secSwSet == '0 && secSwClr == '0) |=> $stable(secCpuIrq[SEC_N-1:SEC_HW_N]))
    else $error("software interrupt changed without request");

  a_sec_best: assert property (@(posedge clk) disable iff (!nrst)
    secBestValid |-> secCpuIrq[secBestIdx])
    else $error("secondary best index not pending");

  // set when a pending source beats the chosen one, or the chosen priority is not its own
  logic urgentMiss;
  always_comb begin
    urgentMiss = 1'b0;
    for (int i = 0; i < NSRC; i++) begin
      if (srcIrq[i] && (!mainValid_d || mainPrio[i] < mainPrio_d)) begin
        urgentMiss = 1'b1;
      end
    end
    if (mainValid_d && mainPrio[mainSrc_d] != mainPrio_d) begin
      urgentMiss = 1'b1;
    end
  end

  a_main_best: assert property (@(posedge clk) disable iff (!nrst)
    !urgentMiss && (!mainBestValid || mainCpuIrq[mainBestSrc]))
    else $error("main best source not the most urgent pending one");

  a_nmi_gated: assert property (@(posedge clk) disable iff (!nrst)
    (nmiEn[0] == '0) |=> !nmiOut[0])
    else $error("nmi raised with no route enabled");

  a_wake_sleep: assert property (@(posedge clk) disable iff (!nrst)
    wakeReq |-> $past(deepSleep) && $past(|srcIrq[NWAKE-1:0]))
    else $error("wake outside deep sleep or without source");

  c_sw_line: cover property (@(posedge clk) disable iff (!nrst)
    secBestValid && secBestIdx >= SEC_IDX_W'(SEC_HW_N));
  c_nmi_main: cover property (@(posedge clk) disable iff (!nrst) nmiOut[0]);

endmodule

//--- inc/irq_ipc_pkg.sv
// Purpose: shared constants and types for interrupt routing and core-to-core channels
// Assumes: both cores and all interrupt sources run on the block clock
// Notes: priority value 0 is the most urgent

package irq_ipc_pkg;

  // ****************************************
  // interrupt routing
  // ****************************************
  localparam int SRC_N = 175;
  localparam int SRC_IDX_W = 8;
  localparam int MAIN_PRIO_W = 3;
  localparam int SEC_HW_N = 8;
  localparam int SEC_SW_N = 8;
  localparam int SEC_N = SEC_HW_N + SEC_SW_N;
  localparam int SEC_IDX_W = 4;
  localparam int SEC_PRIO_W = 2;
  localparam int NMI_PER_CPU = 4;
  localparam int WAKE_N = 45;

  // ****************************************
  // core-to-core channels
  // ****************************************
  localparam int CPU_N = 2;
  localparam int MAIN_CPU = 0;
  localparam int SEC_CPU = 1;
  localparam int CHAN_N = 16;
  localparam int CHAN_IDX_W = 4;
  localparam int DATA_W = 32;
  localparam logic [DATA_W-1:0] DATA_RST = 32'h0000_0000;

  typedef enum logic [2:0] {
    OP_READ,
    OP_WRITE,
    OP_ACQUIRE,
    OP_RELEASE,
    OP_NOTIFY,
    OP_CLEAR
  } ipc_op_t;

endpackage

//--- verification/core_pair_model.sv
// Purpose: two cores issuing channel requests and taking their answers
// Assumes: one request per core per call of issue, two for issue_pair, answer read on the falling edge after the taking edge
// Notes: released channel and data lines show the inverse of the last request

`timescale 1ns/10ps

module core_pair_model
  import irq_ipc_pkg::*;
(
  input wire logic clk,
  output logic [CPU_N-1:0] ipcReqValid,
  output logic [CPU_N-1:0][2:0] ipcReqOp,
  output logic [CPU_N-1:0][CHAN_IDX_W-1:0] ipcReqChan,
  output logic [CPU_N-1:0][DATA_W-1:0] ipcReqData,
  input wire logic [CPU_N-1:0] ipcAckValid,
  input wire logic [CPU_N-1:0] ipcAckOk,
  input wire logic [CPU_N-1:0][DATA_W-1:0] ipcAckData
);
  logic [CPU_N-1:0] okSeen;
  logic [CPU_N-1:0][DATA_W-1:0] dataSeen;
  logic ackMissing;

  initial begin
    ipcReqValid = '0;
    ipcReqOp = '0;
    ipcReqChan = '0;
    ipcReqData = '0;
  end

  // ****************************************
  // request and answer
  // ****************************************
  // software raises notify and release events through these requests
  task automatic issue(input logic [1:0] v, input logic [5:0] ops, input logic [7:0] chs,
                       input logic [63:0] ds);
    @(negedge clk);
    ipcReqValid = v;
    ipcReqOp = ops;
    ipcReqChan = chs;
    ipcReqData = ds;
    @(posedge clk);
    @(negedge clk);
    ackMissing = ((ipcAckValid & v) !== v);
    okSeen = ipcAckOk;
    dataSeen = ipcAckData;
    ipcReqValid = '0;
    ipcReqChan = ~chs;
    ipcReqData = ~ds;
  endtask

  // two requests on consecutive edges; the first answer is taken while the second is driven
  task automatic issue_pair(input logic [1:0] v1, input logic [5:0] op1, input logic [7:0] ch1,
                            input logic [63:0] d1, input logic [1:0] v2, input logic [5:0] op2,
                            input logic [7:0] ch2);
    @(negedge clk);
    ipcReqValid = v1;
    ipcReqOp = op1;
    ipcReqChan = ch1;
    ipcReqData = d1;
    @(posedge clk);
    @(negedge clk);
    okSeen = ipcAckOk;
    ipcReqValid = v2;
    ipcReqOp = op2;
    ipcReqChan = ch2;
    @(posedge clk);
    @(negedge clk);
    ackMissing = ((ipcAckValid & v2) !== v2);
    dataSeen = ipcAckData;
    ipcReqValid = '0;
    ipcReqChan = ~ch2;
    ipcReqData = ~d1;
  endtask
endmodule

//--- verification/dual_cpu_irq_routing_ipc_tb.sv
// Purpose: self-checking bench for interrupt routing and core-to-core channels
// Assumes: inputs change on the falling edge, outputs are one cycle behind
// Notes: channels 8..15, secondary line 7 and secondary nmi stay unused

`timescale 1ns/10ps

module dual_cpu_irq_routing_ipc_tb;
  import irq_ipc_pkg::*;
  typedef struct {logic [7:0] src; logic [2:0] line; logic [2:0] prio;} route_row_t;
  logic clk, nrst, deepSleep, mainBestValid, secBestValid, wakeReq;
  logic [SRC_N-1:0] srcIrq, mainCpuIrq;
  logic [SRC_N-1:0][MAIN_PRIO_W-1:0] mainPrio;
  logic [SEC_HW_N-1:0][SRC_N-1:0] secMap;
  logic [SEC_N-1:0][SEC_PRIO_W-1:0] secPrio;
  logic [SEC_SW_N-1:0] secSwSet, secSwClr;
  logic [CPU_N-1:0][NMI_PER_CPU-1:0] nmiEn;
  logic [CPU_N-1:0][NMI_PER_CPU-1:0][SRC_IDX_W-1:0] nmiSel;
  logic [WAKE_N-1:0] wakeMask;
  logic [CPU_N-1:0] ipcReqValid, ipcAckValid, ipcAckOk, nmiOut;
  logic [CPU_N-1:0][2:0] ipcReqOp;
  logic [CPU_N-1:0][CHAN_IDX_W-1:0] ipcReqChan;
  logic [CPU_N-1:0][DATA_W-1:0] ipcReqData, ipcAckData;
  logic [CPU_N-1:0][CHAN_N-1:0] ipcEvtIrq;
  logic [CHAN_N-1:0] ipcLockState;
  logic [SRC_IDX_W-1:0] mainBestSrc;
  logic [MAIN_PRIO_W-1:0] mainBestPrio;
  logic [SEC_N-1:0] secCpuIrq;
  logic [SEC_IDX_W-1:0] secBestIdx;
  int errTotal = 0;
  int comparisons = 0;
  route_row_t rows [4] = '{'{8'h00, 3'h0, 3'h7}, '{8'hae, 3'h6, 3'h0},
                           '{8'h2c, 3'h3, 3'h5}, '{8'h64, 3'h1, 3'h2}};

  irq_route_ipc dut (.clk, .nrst, .srcIrq, .mainPrio, .secMap, .secPrio, .secSwSet,
    .secSwClr, .nmiEn, .nmiSel, .wakeMask, .deepSleep, .ipcReqValid, .ipcReqOp,
    .ipcReqChan, .ipcReqData, .mainCpuIrq, .mainBestValid, .mainBestSrc, .mainBestPrio,
    .secCpuIrq, .secBestValid, .secBestIdx, .nmiOut, .wakeReq, .ipcAckValid, .ipcAckOk,
    .ipcAckData, .ipcEvtIrq, .ipcLockState);
  core_pair_model cpus (.clk, .ipcReqValid, .ipcReqOp, .ipcReqChan, .ipcReqData,
    .ipcAckValid, .ipcAckOk, .ipcAckData);

  // ****************************************
  // helpers
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic check(input logic [SRC_N-1:0] seen, input logic [SRC_N-1:0] exp,
                       input string what);
    comparisons++;
    if (seen !== exp) begin
      errTotal++;
      $display("CHECK FAILED at %0t: %s", $time, what);
    end
  endtask

  task automatic step();
    @(posedge clk);
    @(negedge clk);
  endtask

  task automatic ipc(input logic [1:0] v, input logic [5:0] ops, input logic [7:0] chs,
                     input logic [63:0] ds, input logic [1:0] okExp);
    cpus.issue(v, ops, chs, ds);
    check(cpus.ackMissing, 1'b0, "answer missing");
    check(cpus.okSeen & v, okExp, "answer status");
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, errTotal);
    if (errTotal == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (3000) @(posedge clk);
    errTotal++;
    give_verdict();
  end

  // ****************************************
  // tests
  // ****************************************
  initial begin
    nrst = 1'b0;
    deepSleep = 1'b0;
    srcIrq = '0;
    mainPrio = '0;
    secMap = '0;
    secPrio = '0;
    secSwSet = '0;
    secSwClr = '0;
    nmiEn = '0;
    nmiSel = '0;
    wakeMask = '0;
    srcIrq[3] = 1'b1;
    repeat (20) @(negedge clk);
    check(mainCpuIrq, '0, "line during reset");
    check(ipcLockState, '0, "lock during reset");
    nrst = 1'b1;
    $display("test reset done");
    foreach (rows[i]) begin
      srcIrq = '0;
      secMap = '0;
      srcIrq[rows[i].src] = 1'b1;
      secMap[rows[i].line][rows[i].src] = 1'b1;
      mainPrio[rows[i].src] = rows[i].prio;
      step();
      check(mainCpuIrq, SRC_N'(1) << rows[i].src, "main line");
      check(secCpuIrq, SRC_N'(1) << rows[i].line, "secondary line");
      check({mainBestSrc, mainBestPrio}, {rows[i].src, rows[i].prio}, "main best");
    end
    $display("test routing rows done");
    srcIrq = '0;
    secMap = '0;
    srcIrq[10] = 1'b1;
    srcIrq[20] = 1'b1;
    secMap[2][10] = 1'b1;
    secMap[2][20] = 1'b1;
    mainPrio[10] = 3'h4;
    mainPrio[20] = 3'h1;
    step();
    check({secCpuIrq, mainBestSrc}, {16'h0004, 8'd20}, "two sources");
    srcIrq[20] = 1'b0;
    step();
    check({secCpuIrq, mainBestSrc}, {16'h0004, 8'd10}, "one source left");
    srcIrq[10] = 1'b0;
    step();
    check({secCpuIrq, mainBestValid, secBestValid}, '0, "no source");
    secPrio[9] = 2'h2;
    secPrio[12] = 2'h1;
    secSwSet = 8'h12;
    step();
    secSwSet = 8'h10;
    secSwClr = 8'h10;
    step();
    check({secCpuIrq, secBestIdx}, {16'h1200, 4'hc}, "software ints held");
    secSwSet = '0;
    step();
    secSwClr = '0;
    step();
    check({secCpuIrq, secBestValid, secBestIdx}, {16'h0200, 1'b1, 4'h9}, "sw int cleared");
    $display("test secondary done");
    // secondary nmi stays with the system functions
    nmiEn[0] = 4'hf;
    for (int k = 0; k < 4; k++) begin
      nmiSel[0][k] = 8'(k * 50 + 5);
    end
    for (int k = 0; k < 4; k++) begin
      srcIrq = '0;
      srcIrq[k * 50 + 5] = 1'b1;
      step();
      check(nmiOut, 2'b01, "nmi route");
    end
    nmiSel[0][3] = 8'hc8;
    step();
    check(nmiOut, 2'b00, "nmi select out of range");
    srcIrq = '0;
    srcIrq[44] = 1'b1;
    wakeMask[44] = 1'b1;
    step();
    check(wakeReq, 1'b0, "wake while awake");
    deepSleep = 1'b1;
    step();
    check(wakeReq, 1'b1, "wake source");
    wakeMask[44] = 1'b0;
    step();
    check(wakeReq, 1'b0, "wake masked");
    $display("test nmi and wake done");
    // only channels 0..7 belong to the application
    ipc(2'b01, {OP_READ, OP_ACQUIRE}, 8'h03, '0, 2'b01);
    check(ipcLockState, 16'h0008, "lock taken");
    ipc(2'b10, {OP_ACQUIRE, OP_READ}, 8'h30, '0, 2'b00);
    ipc(2'b10, {OP_WRITE, OP_READ}, 8'h30, 64'h1234_5678_0000_0000, 2'b00);
    ipc(2'b01, {OP_READ, OP_WRITE}, 8'h03, 64'h0000_0000_cafe_f00d, 2'b01);
    ipc(2'b01, {OP_READ, OP_RELEASE}, 8'h03, '0, 2'b01);
    check({ipcLockState, ipcEvtIrq}, {16'h0000, 16'h0008, 16'h0000}, "release event");
    ipc(2'b10, {OP_READ, OP_READ}, 8'h30, '0, 2'b10);
    check(cpus.dataSeen[1], 32'hcafe_f00d, "data passed");
    ipc(2'b10, {OP_CLEAR, OP_READ}, 8'h30, '0, 2'b10);
    ipc(2'b10, {OP_NOTIFY, OP_READ}, 8'h50, '0, 2'b10);
    check(ipcEvtIrq, {16'h0000, 16'h0020}, "notify event");
    ipc(2'b01, {OP_READ, OP_CLEAR}, 8'h05, '0, 2'b01);
    check(ipcEvtIrq, '0, "events cleared");
    ipc(2'b11, {OP_ACQUIRE, OP_ACQUIRE}, 8'h66, '0, 2'b01);
    ipc(2'b10, {3'h7, OP_READ}, 8'h70, '0, 2'b00);
    check(ipcLockState, 16'h0040, "contest lock");
    cpus.issue_pair(2'b01, {OP_READ, OP_WRITE}, 8'h06, 64'h0000_0000_5a5a_0001,
                    2'b10, {OP_READ, OP_READ}, 8'h66);
    check(cpus.okSeen & 2'b01, 2'b01, "back to back write");
    check(cpus.ackMissing, 1'b0, "back to back answer");
    check(cpus.dataSeen, {32'h5a5a_0001, 32'h0000_0000}, "back to back data");
    $display("test channels done");
    nrst = 1'b0;
    step();
    check({ipcLockState, ipcEvtIrq, secCpuIrq, nmiOut, mainBestValid}, '0, "mid-run reset");
    check(mainCpuIrq, '0, "line in mid-run reset");
    nrst = 1'b1;
    step();
    check(mainCpuIrq, SRC_N'(1) << 44, "line after reset");
    check(wakeReq, 1'b0, "wake masked after reset");
    $display("test mid-run reset done");
    give_verdict();
  end
endmodule
